// >>> rtl/stl_top.sv
// Torque demand clamping and sequence status outputs of a servo drive.
// Assumes settings are quasi-static and the pin inputs are asynchronous.
// Function
// R1: Torque equals input gain times voltage
// R2: Separate forward and reverse internal limits
// R3: External limit input clamps that direction
// R4: Internal limits always win over external; the code keeps the lower of the two, so a lower external limit wins
// R5: Overtravel stop clamps to overtravel limit
// R6: One overtravel limit for both directions
// R7: Add signed bias at servo-on
// R8: Position complete within width, slow pulses
// R9: Position position_approach_out within width, slow pulses
// R10: Speed match when assigned and within range
// R11: Rotation detected above threshold speed
// R12: Clamp small speed commands to zero
// R13: Clamp pin active only when assigned
// R14: Nonzero clamp level clamps automatically
// R15: Wait programmed delay before brake release
// R16: Servo-on strictly precedes brake release
// R17: All outputs updated once per cycle
module stl_top
   import stl_pkg::*;
#(
   parameter int unsigned BRAKE_CYC = BRAKE_UNIT_CYC   // Cycles per brake unit
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Settings
   input  wire logic [GAIN_W-1:0]       cmdGain,          // Tenths %/V
   input  wire logic [LIM_W-1:0]        fwdIntLimit,      // Percent
   input  wire logic [LIM_W-1:0]        revIntLimit,      // Percent
   input  wire logic [LIM_W-1:0]        fwdExtLimit,      // Percent
   input  wire logic [LIM_W-1:0]        revExtLimit,      // Percent
   input  wire logic [LIM_W-1:0]        otLimit,          // Percent
   input  wire logic signed [7:0]       torqueBias,       // Percent, -100..100
   input  wire logic [7:0]              completeWidth,    // Pulses
   input  wire logic [7:0]              nearWidth,        // Pulses
   input  wire logic [9:0]              matchRange,       // Rpm
   input  wire logic [SPD_W-1:0]        rotThreshold,     // Rpm
   input  wire logic [12:0]             clampLevel,       // Rpm
   input  wire logic [DLY_W-1:0]        brakeDelay,       // 10 ms units
   input  wire logic                    positionMode,     // 1 position, 0 speed
   input  wire logic                    matchAssigned,    // Speed match has a pin
   input  wire logic                    clampAssigned,    // Clamp input has a pin
   // Measured values, same clock
   input  wire logic signed [VIN_W-1:0] analogMv,         // Sampled input, mV
   input  wire logic signed [ERR_W-1:0] positionError,    // Pulses
   input  wire logic [15:0]             pulseRate,        // Command pps
   input  wire logic signed [SPD_W-1:0] speedCmd,         // Rpm
   input  wire logic signed [SPD_W-1:0] speedFbk,         // Rpm
   input  wire logic                    servoOn,          // Servo enabled
   // Sequence pins, asynchronous
   input  wire logic                    fwd_ext_torque_limit_in,
   input  wire logic                    rev_ext_torque_limit_in,
   input  wire logic                    fwd_overtravel_in,
   input  wire logic                    rev_overtravel_in,
   input  wire logic                    zero_speed_clamp_in,
   // Results
   output logic signed [TQ_W-1:0]       torqueDemand,     // Tenths of percent
   output logic signed [SPD_W-1:0]      speedDemand,      // Rpm after clamp
   output logic                         position_complete_out,
   output logic                         position_approach_out,
   output logic                         speed_match_out,
   output logic                         rotation_detected_out,
   output logic                         brakeRelease      // High frees brake
);
   // ==========================================================
   // Helpers
   // ==========================================================
   // Magnitude of a signed 16-bit value
   function automatic logic [15:0] absVal(input logic signed [15:0] v);
      absVal = v[15] ? 16'(-v) : 16'(v);
   endfunction

   // Percent limit to tenths of a percent
   function automatic logic signed [TQ_W-1:0] toTenths(input logic [LIM_W-1:0] p);
      toTenths = TQ_W'({5'h00, p} * 14'h000A);
   endfunction

   // Smaller of two signed torque values
   function automatic logic signed [TQ_W-1:0] minTq(input logic signed [TQ_W-1:0] a,
                                                    input logic signed [TQ_W-1:0] b);
      minTq = (a < b) ? a : b;
   endfunction

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [4:0] pinMeta;   // First stage, read only by pinSync
   logic [4:0] pinSync;   // Safe for logic

   // Two flops guard against metastability on the pins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pinMeta <= 5'h00;
         pinSync <= 5'h00;
      end else begin
         pinMeta <= {zero_speed_clamp_in, rev_overtravel_in, fwd_overtravel_in,
                     rev_ext_torque_limit_in, fwd_ext_torque_limit_in};
         pinSync <= pinMeta;
      end
   end

   logic fwdExt;
   logic revExt;
   logic fwdOt;
   logic revOt;
   logic clampPin;
   assign fwdExt   = pinSync[0];
   assign revExt   = pinSync[1];
   assign fwdOt    = pinSync[2];
   assign revOt    = pinSync[3];
   assign clampPin = pinSync[4];

   // ==========================================================
   // Torque command
   // ==========================================================
   logic signed [23:0]     rawProd;     // Gain x mV, tenths % x mV
   logic signed [TQ_W-1:0] rawTq;       // Tenths of percent, saturated
   logic signed [TQ_W-1:0] biasTq;      // Bias in tenths
   logic signed [TQ_W-1:0] fwdCap;      // Positive-side ceiling
   logic signed [TQ_W-1:0] revCap;      // Negative-side magnitude ceiling
   logic signed [TQ_W-1:0] sumTq;       // Command plus bias
   logic signed [TQ_W-1:0] next_torque;

   // Tenths%/V times mV gives tenths% x 1000; divide back out
   always_comb begin
      rawProd = 24'($signed({1'b0, cmdGain}) * analogMv);  // R1
      if (rawProd / 1000 > 24'sd2047) begin
         rawTq = 14'sh07FF;  // Saturate high
      end else if (rawProd / 1000 < -24'sd2047) begin
         rawTq = -14'sh07FF;  // Saturate low
      end else begin
         rawTq = TQ_W'(rawProd / 1000);
      end
   end

   // Bias applies only while servo is on
   always_comb begin
      biasTq = servoOn ? TQ_W'(torqueBias * 14'sd10) : 14'sh0000;  // R7
      sumTq  = rawTq + biasTq;
   end

   // Build the direction ceilings; min lets the lower of internal and external limit win
   always_comb begin
      fwdCap = toTenths(fwdIntLimit);  // R2
      revCap = toTenths(revIntLimit);  // R2
      if (fwdExt) begin
         fwdCap = minTq(fwdCap, toTenths(fwdExtLimit));  // R3 R4
      end
      if (revExt) begin
         revCap = minTq(revCap, toTenths(revExtLimit));  // R3 R4
      end
      if (fwdOt || revOt) begin
         // Same overtravel ceiling both ways
         fwdCap = minTq(fwdCap, toTenths(otLimit));  // R5 R6
         revCap = minTq(revCap, toTenths(otLimit));  // R5 R6
      end
   end

   // Clamp the summed demand into [-revCap, fwdCap]
   always_comb begin
      if (sumTq > fwdCap) begin
         next_torque = fwdCap;
      end else if (sumTq < -revCap) begin
         next_torque = -revCap;
      end else begin
         next_torque = sumTq;
      end
   end

   // Registered torque demand
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         torqueDemand <= 14'sh0000;
      end else begin
         torqueDemand <= next_torque;  // R17
      end
   end

   // ==========================================================
   // Zero clamp
   // ==========================================================
   logic clampActive;   // Clamping in force

   // Nonzero level clamps by itself; else the assigned pin decides
   assign clampActive = !positionMode &&
                        ((clampLevel != 13'h0000) || (clampAssigned && clampPin));  // R13 R14

   // Clamp only affects speed mode commands below the level
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         speedDemand <= 16'sh0000;
      end else if (clampActive && absVal(speedCmd) < {3'h0, clampLevel}) begin
         speedDemand <= 16'sh0000;  // R12
      end else begin
         speedDemand <= speedCmd;  // R12
      end
   end

   // ==========================================================
   // Sequence status outputs
   // ==========================================================
   logic [15:0] errMag;    // Position error magnitude
   logic [15:0] spdErr;    // Speed error magnitude
   logic        slowCmd;   // Command pulses nearly stopped

   assign errMag  = absVal(positionError);
   assign spdErr  = absVal(16'(speedCmd - speedFbk));
   assign slowCmd = pulseRate < 16'(PULSE_RATE_LIM);

   // Position complete and position_approach_out, position mode only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         position_complete_out <= 1'b0;
         position_approach_out <= 1'b0;
      end else begin
         position_complete_out <= positionMode && slowCmd &&
                                  errMag <= {8'h00, completeWidth};  // R8 R17
         position_approach_out <= positionMode && slowCmd &&
                                  errMag <= {8'h00, nearWidth};  // R9 R17
      end
   end

   // Speed match, speed mode and assigned pin only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         speed_match_out <= 1'b0;
      end else begin
         speed_match_out <= !positionMode && matchAssigned &&
                            spdErr <= {6'h00, matchRange};  // R10 R17
      end
   end

   // Rotation detect; a low threshold will chatter on vibration
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rotation_detected_out <= 1'b0;
      end else begin
         rotation_detected_out <= absVal(speedFbk) > rotThreshold;  // R11 R17
      end
   end

   // ==========================================================
   // Brake release timing
   // ==========================================================
   stl_brake_timer #(
      .UNIT_CYC     (BRAKE_CYC)
   ) uBrake (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .servoOn      (servoOn),
      .delayUnits   (brakeDelay),
      .brakeRelease (brakeRelease)  // R15 R16
   );
endmodule

// >>> rtl/stl_pkg.sv
// Constants for the servo torque limit and sequence status block.
// Assumes one 125 MHz control clock and settings held stable by the caller.
package stl_pkg;
   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int unsigned CLK_HZ          = 125_000_000;            // Control clock rate
   localparam int unsigned BRAKE_UNIT_MS   = 10;                     // Brake delay unit
   localparam int unsigned BRAKE_UNIT_CYC  = CLK_HZ / 1000 * BRAKE_UNIT_MS; // Cycles per unit
   localparam int unsigned PULSE_RATE_LIM  = 100;                    // Settle rate, pps

   // ==========================================================
   // Widths
   // ==========================================================
   localparam int unsigned TQ_W   = 14;   // Signed torque, tenths; room for 300 % plus bias
   localparam int unsigned GAIN_W = 10;   // Gain, tenths of a percent per volt
   localparam int unsigned VIN_W  = 12;   // Signed input, millivolts
   localparam int unsigned LIM_W  = 9;    // Limit, whole percent
   localparam int unsigned SPD_W  = 16;   // Signed speed, rpm
   localparam int unsigned ERR_W  = 16;   // Signed position error, pulses
   localparam int unsigned DLY_W  = 10;   // Brake delay count, units

   // ==========================================================
   // Values after reset
   // ==========================================================
   localparam logic [GAIN_W-1:0] GAIN_RST      = 10'h14D;  // 33.3 %/V
   localparam logic [LIM_W-1:0]  INT_LIM_RST   = 9'h12C;   // 300 %
   localparam logic [LIM_W-1:0]  EXT_LIM_RST   = 9'h064;   // 100 %
   localparam logic [LIM_W-1:0]  OT_LIM_RST    = 9'h12C;   // 300 %
   localparam logic [7:0]        COMP_W_RST    = 8'h0A;    // 10 pulses
   localparam logic [7:0]        POSITION_APPROACH_OUT_W_RST    = 8'h14;    // 20 pulses
   localparam logic [9:0]        MATCH_RST     = 10'h00A;  // 10 rpm

   // Brake sequencer states
   typedef enum logic [1:0] {
      STL_BRK_HELD = 2'b00,
      STL_BRK_WAIT = 2'b01,
      STL_BRK_FREE = 2'b10
   } stl_brk_e;
endpackage

// >>> rtl/stl_brake_timer.sv
// Brake release sequencer: delays release after servo-on.
// Assumes servoOn is synchronous to sys_clk.
module stl_brake_timer
   import stl_pkg::*;
#(
   parameter int unsigned UNIT_CYC = BRAKE_UNIT_CYC   // Cycles per 10 ms unit
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             servoOn,      // Servo enabled this cycle
   input  wire logic [DLY_W-1:0] delayUnits,   // Wait in 10 ms units
   output logic                  brakeRelease  // High releases the brake
);
   // ==========================================================
   // State
   // ==========================================================
   stl_brk_e         state;      // Sequencer state
   logic [31:0]      tick;       // Cycles within a unit
   logic [DLY_W-1:0] units;      // Whole units elapsed

   // Sequencer; release always trails servo-on by at least a cycle
   always_ff @(posedge sys_clk) begin
      if (rst || !servoOn) begin
         state        <= STL_BRK_HELD;  // Servo off always holds brake
         tick         <= '0;
         units        <= '0;
         brakeRelease <= 1'b0;
      end else begin
         case (state)
            STL_BRK_HELD: begin
               state <= STL_BRK_WAIT;  // R16
            end
            STL_BRK_WAIT: begin
               if (units >= delayUnits) begin
                  state        <= STL_BRK_FREE;  // R15
                  brakeRelease <= 1'b1;
               end else if (tick == UNIT_CYC - 1) begin
                  tick  <= '0;
                  units <= units + 1'b1;
               end else begin
                  tick <= tick + 1;
               end
            end
            STL_BRK_FREE: begin
               brakeRelease <= 1'b1;
            end
            default: begin
               state <= STL_BRK_HELD;
            end
         endcase
      end
   end
endmodule

// >>> dv/stl_top_props.sv
// Checker for torque clamping, status outputs and brake order of stl_top.
// Assumes it is bound into stl_top and sees only that module's ports.
module stl_top_props
   import stl_pkg::*;
#(
   parameter int unsigned BRAKE_CYC = BRAKE_UNIT_CYC   // Cycles per brake unit
) (
   input wire logic                    sys_clk,
   input wire logic                    rst,
   input wire logic [LIM_W-1:0]        fwdIntLimit,
   input wire logic [LIM_W-1:0]        revIntLimit,
   input wire logic [LIM_W-1:0]        otLimit,
   input wire logic [7:0]              completeWidth,
   input wire logic [7:0]              nearWidth,
   input wire logic [9:0]              matchRange,
   input wire logic [SPD_W-1:0]        rotThreshold,
   input wire logic [12:0]             clampLevel,
   input wire logic [DLY_W-1:0]        brakeDelay,
   input wire logic                    positionMode,
   input wire logic                    matchAssigned,
   input wire logic signed [ERR_W-1:0] positionError,
   input wire logic [15:0]             pulseRate,
   input wire logic signed [SPD_W-1:0] speedCmd,
   input wire logic signed [SPD_W-1:0] speedFbk,
   input wire logic                    servoOn,
   input wire logic                    fwd_overtravel_in,
   input wire logic                    rev_overtravel_in,
   input wire logic signed [TQ_W-1:0]  torqueDemand,
   input wire logic signed [SPD_W-1:0] speedDemand,
   input wire logic                    position_complete_out,
   input wire logic                    position_approach_out,
   input wire logic                    speed_match_out,
   input wire logic                    rotation_detected_out,
   input wire logic                    brakeRelease
);
   // ==========================================================
   // Helper values
   // ==========================================================
   function automatic int mag(int v);
      return (v < 0) ? -v : v;
   endfunction
   int   aErr, aDif, aCmd, aFbk, tq, fCap, rCap, oCap;
   int   onCnt;   // Cycles servoOn has been high
   logic live;    // Low on the first edge after reset, outputs still cleared
   assign aErr = mag(positionError);
   assign aDif = mag(speedCmd - speedFbk);
   assign aCmd = mag(speedCmd);
   assign aFbk = mag(speedFbk);
   assign tq   = torqueDemand;
   assign fCap = fwdIntLimit * 10;
   assign rCap = revIntLimit * 10;
   assign oCap = otLimit * 10;
   // Servo-on age and reset aftermath
   always_ff @(posedge sys_clk) begin
      onCnt <= (rst || !servoOn) ? 0 : onCnt + 1;
      live  <= !rst;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // Assertions
   // ==========================================================
   cmp_width_a: assert property (live |=> position_complete_out ==
      $past(positionMode && aErr <= completeWidth && pulseRate < 16'h0064))
      else $error("position complete wrong");
   position_approach_out_width_a: assert property (live |=> position_approach_out ==
      $past(positionMode && aErr <= nearWidth && pulseRate < 16'h0064))
      else $error("position position_approach_out wrong");
   speed_match_a: assert property (live |=> speed_match_out ==
      $past(!positionMode && matchAssigned && aDif <= matchRange))
      else $error("speed match wrong");
   rot_detect_a: assert property (live |=> rotation_detected_out == $past(aFbk > rotThreshold))
      else $error("rotation detect wrong");
   int_cap_a: assert property (live |=> tq <= $past(fCap) && tq >= -$past(rCap))
      else $error("torque beyond internal limit");
   ot_cap_a: assert property ((fwd_overtravel_in || rev_overtravel_in) [*4]
      |=> tq <= $past(oCap) && tq >= -$past(oCap)) else $error("overtravel clamp missed");
   zero_clamp_a: assert property (live && !positionMode && clampLevel != 13'h0000
      && aCmd < clampLevel |=> speedDemand == 16'h0000) else $error("small command not zeroed");
   brake_order_a: assert property ($rose(brakeRelease) |-> $past(servoOn) && $past(servoOn, 2))
      else $error("brake freed before servo on");
   brake_wait_a: assert property ($rose(brakeRelease) |-> onCnt >= brakeDelay * BRAKE_CYC)
      else $error("brake freed too early");
   brake_fast_a: assert property (live && $rose(servoOn) && brakeDelay == 10'h000
      |-> ##[1:3] brakeRelease) else $error("brake not freed");
   cover property ($rose(position_complete_out));
   cover property ($rose(brakeRelease) && brakeDelay != 10'h000);
   cover property (rev_overtravel_in [*4] ##1 tq == oCap);
endmodule

bind stl_top stl_top_props #(.BRAKE_CYC(BRAKE_CYC)) i_stl_top_props (.sys_clk, .rst,
   .fwdIntLimit, .revIntLimit, .otLimit, .completeWidth, .nearWidth, .matchRange,
   .rotThreshold, .clampLevel, .brakeDelay, .positionMode, .matchAssigned, .positionError,
   .pulseRate, .speedCmd, .speedFbk, .servoOn, .fwd_overtravel_in, .rev_overtravel_in,
   .torqueDemand, .speedDemand, .position_complete_out, .position_approach_out,
   .speed_match_out, .rotation_detected_out, .brakeRelease);

// >>> dv/stl_ctrl_model.sv
// Motion controller model that drives the drive's sequence pins.
// Assumes the bench sets the wanted levels; pins change just after an edge.
module stl_ctrl_model (
   input  wire logic       sys_clk,
   input  wire logic [4:0] pinReq,   // Wanted levels
   output logic      [4:0] pinOut    // fwd tl, rev tl, fwd ot, rev ot, zero clamp
);
   // ==========================================================
   // Pin drive
   // ==========================================================
   // Registered, so a pin never moves on the edge the drive samples it
   always @(posedge sys_clk) pinOut <= pinReq;
endmodule

// >>> dv/tb_stl_top.sv
// Self-checking bench for stl_top: torque clamps, status outputs, brake.
// Assumes stl_pkg is compiled first and the checker binds itself in.
module tb_stl_top;
   import stl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Stimulus and results
   // ==========================================================
   logic sys_clk = 1'b0, rst = 1'b1, servoOn = 1'b0, positionMode = 1'b0;
   logic matchAssigned = 1'b1, clampAssigned = 1'b0;
   logic [GAIN_W-1:0] cmdGain = GAIN_RST;
   logic [LIM_W-1:0] fwdIntLimit = INT_LIM_RST, revIntLimit = INT_LIM_RST, otLimit = OT_LIM_RST;
   logic [LIM_W-1:0] fwdExtLimit = EXT_LIM_RST, revExtLimit = EXT_LIM_RST;
   logic signed [7:0] torqueBias = 8'h00;
   logic [7:0] completeWidth = COMP_W_RST, nearWidth = POSITION_APPROACH_OUT_W_RST;
   logic [9:0] matchRange = MATCH_RST, brakeDelay = 10'h000;
   logic [SPD_W-1:0] rotThreshold = 16'h0064;
   logic [12:0] clampLevel = 13'h0000;
   logic signed [15:0] analogMv = 16'h0000, positionError = 16'h0000;
   logic signed [15:0] speedCmd = 16'h0000, speedFbk = 16'h0000;
   logic [15:0] pulseRate = 16'h0000;
   logic [4:0] pinReq = 5'h00;
   wire  [4:0] pins;
   logic signed [TQ_W-1:0] torqueDemand;
   logic signed [SPD_W-1:0] speedDemand;
   logic pComp, pNear, sMatch, rotDet, brakeRelease;
   int n_mismatch = 0, n_checks = 0, cycles = 0, n;
   int errT[6] = '{10, -15, 21, 0, -10, 20};
   int rateT[6] = '{99, 99, 0, 100, 0, 5};
   int compT[6] = '{1, 0, 0, 0, 1, 0};
   int nearT[6] = '{1, 1, 0, 0, 1, 1};
   int fbkT[6] = '{490, 489, 510, 510, 100, -101};
   int asgT[6] = '{1, 1, 1, 0, 1, 1};
   int matT[6] = '{1, 0, 1, 0, 0, 0};
   int rotT[6] = '{1, 1, 1, 1, 0, 1};
   int cmdT[4] = '{49, -49, 50, -50};
   int zclT[4] = '{0, 0, 50, -50};
   stl_ctrl_model i_stl_ctrl_model (.sys_clk(sys_clk), .pinReq(pinReq), .pinOut(pins));
   stl_top #(.BRAKE_CYC(4)) i_stl_top (.sys_clk, .rst, .cmdGain, .fwdIntLimit, .revIntLimit,
      .fwdExtLimit, .revExtLimit, .otLimit, .torqueBias, .completeWidth, .nearWidth,
      .matchRange, .rotThreshold, .clampLevel, .brakeDelay, .positionMode, .matchAssigned,
      .clampAssigned, .analogMv(analogMv[11:0]), .positionError, .pulseRate, .speedCmd,
      .speedFbk, .servoOn, .fwd_ext_torque_limit_in(pins[0]),
      .rev_ext_torque_limit_in(pins[1]), .fwd_overtravel_in(pins[2]),
      .rev_overtravel_in(pins[3]), .zero_speed_clamp_in(pins[4]), .torqueDemand,
      .speedDemand, .position_complete_out(pComp), .position_approach_out(pNear),
      .speed_match_out(sMatch), .rotation_detected_out(rotDet), .brakeRelease);
   // ==========================================================
   // Clock, timeout and shared tasks
   // ==========================================================
   initial forever #4 sys_clk = ~sys_clk;
   // Ceiling well above the hundred or so cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic chk(input string what, input logic signed [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   // Let n edges pass, then look once the outputs have settled
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      step(1);
      chk("torqueReset", torqueDemand, 0);
      @(posedge sys_clk) analogMv <= 16'sd1000;
      step(2);
      chk("torqueGain", torqueDemand, 333);
      @(posedge sys_clk) begin
         cmdGain <= 10'h3E8;
         analogMv <= 16'sd2000;
         fwdIntLimit <= 9'h096;
         revIntLimit <= 9'h078;
      end
      step(2);
      chk("fwdInternal", torqueDemand, 1500);
      @(posedge sys_clk) analogMv <= -16'sd2000;
      step(2);
      chk("revInternal", torqueDemand, -1200);
      // External limit below, then above, the internal one
      @(posedge sys_clk) begin
         analogMv <= 16'sd2000;
         pinReq <= 5'h01;
      end
      step(5);
      chk("fwdExternal", torqueDemand, 1000);
      @(posedge sys_clk) fwdExtLimit <= 9'h0FA;
      step(2);
      chk("extOverInt", torqueDemand, 1500);
      // One overtravel pin caps both directions
      @(posedge sys_clk) begin
         pinReq <= 5'h08;
         otLimit <= 9'h032;
      end
      step(5);
      chk("otFwd", torqueDemand, 500);
      @(posedge sys_clk) analogMv <= -16'sd2000;
      step(2);
      chk("otRev", torqueDemand, -500);
      // Servo-on brings bias and, after the wait, brake release
      for (int d = 2; d >= 0; d -= 2) begin
         @(posedge sys_clk) begin
            pinReq <= 5'h00;
            analogMv <= 16'sd0;
            torqueBias <= 8'sd10;
            brakeDelay <= 10'(d);
            servoOn <= 1'b1;
         end
         n = 0;
         do begin
            step(1);
            n++;
         end while (brakeRelease !== 1'b1 && n < 40);
         chk("brakeWait", n >= d * 4 && n <= d * 4 + 4, 1);
         chk("biasOn", torqueDemand, 100);
         @(posedge sys_clk) servoOn <= 1'b0;
         step(2);
         chk("brakeHeld", brakeRelease, 0);
         chk("biasOff", torqueDemand, 0);
      end
      @(posedge sys_clk) positionMode <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk) begin
            positionError <= 16'(errT[i]);
            pulseRate <= 16'(rateT[i]);
         end
         step(2);
         chk("posComplete", pComp, compT[i]);
         chk("posNear", pNear, nearT[i]);
      end
      @(posedge sys_clk) begin
         positionMode <= 1'b0;
         speedCmd <= 16'sd500;
      end
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk) begin
            speedFbk <= 16'(fbkT[i]);
            matchAssigned <= 1'(asgT[i]);
         end
         step(2);
         chk("speedMatch", sMatch, matT[i]);
         chk("rotation", rotDet, rotT[i]);
      end
      // Level alone clamps, with the clamp pin unassigned and idle
      @(posedge sys_clk) clampLevel <= 13'h0032;
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk) speedCmd <= 16'(cmdT[i]);
         step(2);
         chk("zeroClamp", speedDemand, zclT[i]);
      end
      @(posedge sys_clk) begin
         clampLevel <= 13'h0000;
         clampAssigned <= 1'b1;
         pinReq <= 5'h10;
         speedCmd <= 16'sd5;
      end
      step(5);
      chk("clampPinZero", speedDemand, 5);
      report_and_stop();
   end
endmodule
